// [verilog/irq_defines.svh]
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH

// status flags register layout and reset value
`define STATUS_GIE_BIT 7
`define STATUS_RESET 8'h00

// stack pointer reset value and bytes moved per return address
`define SP_RESET 16'h00ff
`define PC_STACK_BYTES 16'h0002

// vector table: reset at the bottom, one slot per source above it
`define RESET_VECTOR 16'h0000
`define VECTOR_STRIDE 16'h0002

// cycle counts of the sequences
`define ENTRY_CYCLES 3'h4
`define JUMP_CYCLES 3'h3
`define WAKE_CYCLES 3'h4
`define RETURN_CYCLES 3'h4

`endif

// [verilog/irq_pkg.sv]
package irq_pkg;

  // sequencer states
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_WAKE = 3'b001,
    ST_ENTRY = 3'b010,
    ST_JUMP = 3'b011,
    ST_RETURN = 3'b100
  } irq_state_e;

  typedef logic [15:0] addr_t;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] count_t;

endpackage

// [verilog/irq_pick_if.sv]
`timescale 1ns/1ps
interface irq_pick_if #(
  parameter int N = 8,
  parameter int IDX_W = 3
);
  logic [N-1:0] pending;
  logic any;
  logic [IDX_W-1:0] index;

  modport requester (output pending, input any, input index);
  modport picker (input pending, output any, output index);
endinterface // irq_pick_if

// [verilog/irq_picker.sv]
`timescale 1ns/1ps
module irq_picker #(
  parameter int N = 8,
  parameter int IDX_W = 3
) (
  irq_pick_if.picker pick_if // pending in, winner out
);
  import irq_pkg::*;

  // lowest index wins, it has the lowest vector address
  function automatic logic [IDX_W-1:0] lowest(input logic [N-1:0] v);
    logic [IDX_W-1:0] r;
    r = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IDX_W'(i);
      end
    end
    return r;
  endfunction

  // combinational choice, registered by the sequencer when taken
  assign pick_if.any = |pick_if.pending;
  assign pick_if.index = lowest(pick_if.pending);
endmodule // irq_picker

// [verilog/stack_ram.sv]
`timescale 1ns/1ps
module stack_ram #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clock_i, // core clock
  input wire logic we_i, // write strobe
  input wire logic [AW-1:0] waddr_i, // write address
  input wire irq_pkg::byte_t wdata_i, // write byte
  input wire logic [AW-1:0] raddr_i, // read address
  output irq_pkg::byte_t rdata_o // read byte, one cycle late
);
  import irq_pkg::*;

  byte_t mem [DEPTH];
  byte_t rdata_reg;

  // depth must fill the address space so no address aliases silently
  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("stack_ram: DEPTH must equal 2**AW");
  end

  // write port
  always_ff @(posedge clock_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // read data from a register, no reset needed on a memory
  always_ff @(posedge clock_i) begin
    rdata_reg <= mem[raddr_i];
  end

  assign rdata_o = rdata_reg;
endmodule // stack_ram

// [verilog/cpu_interrupt_entry_exit.sv]
`timescale 1ns/1ps
`include "irq_defines.svh"
module cpu_interrupt_entry_exit #(
  parameter int N = 8,
  parameter logic [N-1:0] FLAG_MASK = '1,
  parameter int STACK_AW = 8
) (
  input wire logic clock_i, // core clock, 100 MHz
  input wire logic rst_i, // synchronous reset, active high
  input wire logic [N-1:0] cond_i, // event pulse or level per source
  input wire logic [N-1:0] enable_i, // per-source enables
  input wire logic [N-1:0] flag_clear_i, // write-one-to-clear strobes
  input wire logic instr_done_i, // instruction boundary
  input wire logic sei_i, // global enable instr at boundary
  input wire logic cli_i, // global disable instr at boundary
  input wire logic return_from_handler_i, // return instr at boundary
  input wire logic status_we_i, // core writes status flags
  input wire irq_pkg::byte_t status_wdata_i, // status write data
  input wire logic sp_we_i, // core writes stack pointer
  input wire irq_pkg::addr_t sp_wdata_i, // stack pointer write data
  input wire logic sleeping_i, // core asleep
  input wire irq_pkg::addr_t pc_i, // address of next instruction
  output logic stall_o, // hold the core
  output logic pc_load_o, // one-cycle pc load pulse
  output irq_pkg::addr_t pc_value_o, // value to load
  output irq_pkg::byte_t status_o, // status_flags_reg
  output logic [N-1:0] flag_o, // pending flags
  output logic [N-1:0] ack_o, // one-cycle service acknowledge
  output irq_pkg::addr_t sp_o, // stack pointer
  output logic wake_o // pulse, wake started
);
  import irq_pkg::*;

  localparam int IDX_W = (N > 1) ? $clog2(N) : 1;

  // vector addresses must fit in 16 bits
  if (N < 1 || N > 1000) begin : g_bad_n
    $error("cpu_interrupt_entry_exit: N out of range");
  end
  if (STACK_AW < 2 || STACK_AW > 16) begin : g_bad_aw
    $error("cpu_interrupt_entry_exit: STACK_AW out of range");
  end

  // vector address of source idx, reset owns the first slot
  function automatic addr_t vec_addr(input logic [IDX_W-1:0] idx);
    return 16'(`RESET_VECTOR + (32'(idx) + 32'h1) * `VECTOR_STRIDE);
  endfunction

  // one-hot mask of a source index
  function automatic logic [N-1:0] onehot(input logic [IDX_W-1:0] idx);
    return N'(1) << idx;
  endfunction

  irq_state_e state_reg, state_next;
  count_t cnt_reg, cnt_next;
  byte_t status_reg, status_next;
  addr_t sp_reg, sp_next;
  addr_t pc_save_reg, pc_save_next;
  addr_t vec_reg, vec_next;
  addr_t ret_pc_reg, ret_pc_next;
  logic [N-1:0] flag_reg, flag_next;
  logic [N-1:0] ack_reg, ack_next;
  logic inhibit_reg, inhibit_next;
  logic boot_reg;
  logic stall_reg;
  logic pc_load_reg, pc_load_next;
  addr_t pc_value_reg, pc_value_next;
  logic wake_reg;

  irq_pick_if #(.N(N), .IDX_W(IDX_W)) pick_if ();

  irq_picker #(.N(N), .IDX_W(IDX_W)) u_picker (
    .pick_if (pick_if)
  );

  logic ram_we;
  logic [STACK_AW-1:0] ram_waddr;
  byte_t ram_wdata;
  logic [STACK_AW-1:0] ram_raddr;
  byte_t ram_rdata;

  stack_ram #(.DEPTH(1 << STACK_AW), .AW(STACK_AW)) u_stack (
    .clock_i (clock_i),
    .we_i (ram_we),
    .waddr_i (ram_waddr),
    .wdata_i (ram_wdata),
    .raddr_i (ram_raddr),
    .rdata_o (ram_rdata)
  );

  // request vector: flag-type from flags, level-type straight from pins
  // level requests
  wire [N-1:0] request = (flag_reg & FLAG_MASK) | (cond_i & ~FLAG_MASK);
  assign pick_if.pending = request & enable_i;

  // global enable as seen this cycle
  // enable at bit 7
  wire gie = status_reg[`STATUS_GIE_BIT];
  // disable wins at once over a boundary take, also by a status write
  wire gie_drop = cli_i | (status_we_i & ~status_wdata_i[`STATUS_GIE_BIT]);

  // boundary: a completed instruction that is not a return
  // wait for instruction end
  wire boundary = instr_done_i & ~return_from_handler_i;
  // no service at the enabling boundary
  wire can_take = gie & ~gie_drop & ~sei_i & ~inhibit_reg & pick_if.any;
  wire take_run = (state_reg == ST_RUN) & boundary & can_take;
  // a sleeping core has no instruction in flight, so any cycle qualifies
  wire take_wake = (state_reg == ST_RUN) & sleeping_i & ~instr_done_i &
                   gie & ~inhibit_reg & pick_if.any;
  wire take = take_run | take_wake;
  wire do_return = (state_reg == ST_RUN) & instr_done_i &
                   return_from_handler_i;

  wire [N-1:0] hw_clear = take ? (onehot(pick_if.index) & FLAG_MASK) : '0;

  // length of the sequence in the current state
  wire count_t seq_len = (state_reg == ST_WAKE) ? `WAKE_CYCLES :
                         (state_reg == ST_ENTRY) ? `ENTRY_CYCLES :
                         (state_reg == ST_JUMP) ? `JUMP_CYCLES :
                         `RETURN_CYCLES;
  wire seq_last = (cnt_reg == seq_len - 3'h1);

  // stack traffic: two pushes at entry, two reads at return
  wire push_lo = (state_reg == ST_ENTRY) & (cnt_reg == 3'h0);
  wire push_hi = (state_reg == ST_ENTRY) & (cnt_reg == 3'h1);
  assign ram_we = push_lo | push_hi;
  assign ram_waddr = sp_reg[STACK_AW-1:0];
  assign ram_wdata = push_lo ? pc_save_reg[7:0] : pc_save_reg[15:8];
  wire addr_t pop_addr = (cnt_reg == 3'h0) ? sp_reg + 16'h0001 :
                         sp_reg + `PC_STACK_BYTES;
  assign ram_raddr = pop_addr[STACK_AW-1:0];

  // flags: set wins over any clear in the same cycle
  // set regardless of enables
  assign flag_next = (flag_reg & ~flag_clear_i & ~hw_clear) |
                     (cond_i & FLAG_MASK);

  // sequencer next state and counter
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ST_RUN: begin
        cnt_next = 3'h0;
        if (do_return) begin
          state_next = ST_RETURN;
        end else if (take_wake) begin
          state_next = ST_WAKE;
        end else if (take_run) begin
          state_next = ST_ENTRY;
        end
      end
      ST_WAKE, ST_ENTRY, ST_JUMP, ST_RETURN: begin
        cnt_next = seq_last ? 3'h0 : cnt_reg + 3'h1;
        if (seq_last) begin
          case (state_reg)
            ST_WAKE: state_next = ST_ENTRY;
            // vector runs after four entry cycles
            ST_ENTRY: state_next = ST_JUMP;
            default: state_next = ST_RUN;
          endcase
        end
      end
      default: begin
        state_next = ST_RUN;
        cnt_next = 3'h0;
      end
    endcase
  end

  // status flags register; only bit 7 is ever changed by hardware
  // arithmetic flags left to software
  always_comb begin
    status_next = status_reg;
    if (status_we_i) begin
      status_next = status_wdata_i;
    end
    if (instr_done_i && sei_i) begin
      status_next[`STATUS_GIE_BIT] = 1'b1;
    end
    if (instr_done_i && cli_i) begin
      status_next[`STATUS_GIE_BIT] = 1'b0;
    end
    if (take) begin
      status_next[`STATUS_GIE_BIT] = 1'b0;
    end
    // handler may set it itself to nest
    if (state_reg == ST_RETURN && seq_last) begin
      status_next[`STATUS_GIE_BIT] = 1'b1;
    end
  end

  // stack pointer: core writes, minus one per push, plus two on return
  always_comb begin
    sp_next = sp_reg;
    if (sp_we_i && state_reg == ST_RUN) begin
      sp_next = sp_wdata_i;
    end
    // two decrements for the return address
    if (ram_we) begin
      sp_next = sp_reg - 16'h0001;
    end
    // plus two at the end of return
    if (state_reg == ST_RETURN && seq_last) begin
      sp_next = sp_reg + `PC_STACK_BYTES;
    end
  end

  // captured return address, vector and popped pc
  // lowest index is the lowest vector address
  // one slot per source above reset
  assign pc_save_next = take ? pc_i : pc_save_reg;
  assign vec_next = take ? vec_addr(pick_if.index) : vec_reg;
  always_comb begin
    ret_pc_next = ret_pc_reg;
    if (state_reg == ST_RETURN && cnt_reg == 3'h1) begin
      ret_pc_next[15:8] = ram_rdata;
    end
    if (state_reg == ST_RETURN && cnt_reg == 3'h2) begin
      ret_pc_next[7:0] = ram_rdata;
    end
  end

  // one-instruction shadow after enable or return
  always_comb begin
    inhibit_next = inhibit_reg;
    if (state_reg == ST_RUN && instr_done_i) begin
      inhibit_next = sei_i;
    end
    if (state_reg == ST_RETURN && seq_last) begin
      inhibit_next = 1'b1;
    end
  end

  // pc load pulse: reset vector, end of vector jump, end of return
  always_comb begin
    pc_load_next = 1'b0;
    pc_value_next = pc_value_reg;
    if (boot_reg) begin
      pc_load_next = 1'b1;
      pc_value_next = `RESET_VECTOR;
    end else if (state_reg == ST_JUMP && seq_last) begin
      pc_load_next = 1'b1;
      pc_value_next = vec_reg;
    end else if (state_reg == ST_RETURN && seq_last) begin
      pc_load_next = 1'b1;
      pc_value_next = {ret_pc_reg[15:8], ret_pc_reg[7:0]};
    end
  end

  assign ack_next = take ? onehot(pick_if.index) : '0;

  // sequencer registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= ST_RUN;
      cnt_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // architectural state
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      status_reg <= `STATUS_RESET;
      sp_reg <= `SP_RESET;
      flag_reg <= '0;
      inhibit_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      sp_reg <= sp_next;
      flag_reg <= flag_next;
      inhibit_reg <= inhibit_next;
    end
  end

  // working registers of entry and return
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pc_save_reg <= 16'h0000;
      vec_reg <= `RESET_VECTOR;
      ret_pc_reg <= 16'h0000;
    end else begin
      pc_save_reg <= pc_save_next;
      vec_reg <= vec_next;
      ret_pc_reg <= ret_pc_next;
    end
  end

  // output registers; stall follows the next state so the core freezes
  // on the very edge that starts a sequence
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      boot_reg <= 1'b1;
      stall_reg <= 1'b0;
      pc_load_reg <= 1'b0;
      pc_value_reg <= `RESET_VECTOR;
      ack_reg <= '0;
      wake_reg <= 1'b0;
    end else begin
      boot_reg <= 1'b0;
      stall_reg <= (state_next != ST_RUN);
      pc_load_reg <= pc_load_next;
      pc_value_reg <= pc_value_next;
      ack_reg <= ack_next;
      wake_reg <= take_wake;
    end
  end

  assign stall_o = stall_reg;
  assign pc_load_o = pc_load_reg;
  assign pc_value_o = pc_value_reg;
  assign status_o = status_reg;
  assign flag_o = flag_reg;
  assign ack_o = ack_reg;
  assign sp_o = sp_reg;
  assign wake_o = wake_reg;
endmodule // cpu_interrupt_entry_exit

// [dv/core_model.sv]
`timescale 1ns/1ps
// stand-in for the core: issues instructions, freezes while held
module core_model (
  input wire logic clock_i, // core clock
  input wire logic rst_i, // synchronous reset
  input wire logic stall_i, // hold from the block
  input wire logic pc_load_i, // pc load pulse
  input wire irq_pkg::addr_t pc_value_i, // value to load
  input wire logic slow_i, // two-cycle instructions
  input wire logic asleep_i, // no instructions while asleep
  output logic done_o, // instruction boundary pulse
  output irq_pkg::addr_t pc_o // address of next instruction
);
  import irq_pkg::*;
  logic half_reg;
  // status flags left to handler code, never saved here
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      half_reg <= 1'b0;
      pc_o <= 16'h0000;
    end else begin
      half_reg <= slow_i & ~half_reg;
      done_o <= ~stall_i & ~asleep_i & ~pc_load_i & (~slow_i | half_reg);
      pc_o <= pc_load_i ? pc_value_i : pc_o + 16'(done_o);
    end
  end
endmodule // core_model

// [dv/cpu_interrupt_entry_exit_checker.sv]
`timescale 1ns/1ps
`include "irq_defines.svh"
module cpu_interrupt_entry_exit_checker #(
  parameter int N = 8,
  parameter logic [N-1:0] FLAG_MASK = '1
) (
  input wire logic clock_i, // core clock
  input wire logic rst_i, // synchronous reset
  input wire logic [N-1:0] cond_i, // source conditions
  input wire logic [N-1:0] enable_i, // source enables
  input wire logic instr_done_i, // boundary
  input wire logic cli_i, // global disable
  input wire logic return_from_handler_i, // return from handler
  input wire logic status_we_i, // status write
  input wire logic sleeping_i, // asleep
  input wire logic stall_o, // hold
  input wire logic pc_load_o, // pc load pulse
  input wire irq_pkg::addr_t pc_value_o, // loaded pc
  input wire irq_pkg::byte_t status_o, // status flags
  input wire logic [N-1:0] flag_o, // pending flags
  input wire logic [N-1:0] ack_o, // taken source
  input wire irq_pkg::addr_t sp_o, // stack pointer
  input wire logic wake_o // wake pulse
);
  import irq_pkg::*;
  logic [N-1:0] req_w;
  // requests that compete; level sources count only while present
  assign req_w = (flag_o | (cond_i & ~FLAG_MASK)) & enable_i;
  function automatic addr_t vec_of(logic [N-1:0] a);
    addr_t v;
    v = '0;
    for (int i = 0; i < N; i++) if (a[i]) v = `VECTOR_STRIDE * addr_t'(i + 1);
    return v;
  endfunction
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_take_needs_gie: assert property (
    |ack_o |-> ($past(status_o[`STATUS_GIE_BIT]) || $past(status_we_i))
      && |($past(enable_i) & ack_o)) else $error("take without enables");
  a_gie_cleared: assert property (
    |ack_o && !$past(status_we_i) |-> !status_o[`STATUS_GIE_BIT])
    else $error("global enable not cleared on take");
  a_lowest_wins: assert property (
    |ack_o |-> ((ack_o - 1'b1) & $past(req_w)) == '0)
    else $error("lower pending source skipped");
  a_entry_vector: assert property (
    |ack_o && !wake_o |-> (stall_o && !pc_load_o) [*7] ##1 (pc_load_o
      && !stall_o && pc_value_o == vec_of($past(ack_o, 7))))
    else $error("entry timing or vector wrong");
  a_wake_delay: assert property (
    wake_o |-> ##11 (pc_load_o && pc_value_o == vec_of($past(ack_o, 11))))
    else $error("wake entry timing wrong");
  a_push_two: assert property (
    |ack_o && !wake_o |-> ##7 sp_o == $past(sp_o, 8) - `PC_STACK_BYTES)
    else $error("push did not lower sp by two");
  a_flag_cleared: assert property (
    |(ack_o & FLAG_MASK) && !(|($past(cond_i) & ack_o))
      |-> !(|(flag_o & ack_o)))
    else $error("flag kept after vectoring");
  a_cli_blocks: assert property (
    instr_done_i && cli_i |=> !(|ack_o)) else $error("take after disable");
  a_boundary_only: assert property (
    |ack_o |-> !$past(stall_o) && ($past(instr_done_i) || $past(sleeping_i)))
    else $error("take off a boundary");
  a_return_path: assert property (
    instr_done_i && return_from_handler_i && !stall_o |-> ##5 (pc_load_o
      && status_o[`STATUS_GIE_BIT]
      && sp_o == $past(sp_o, 5) + `PC_STACK_BYTES))
    else $error("return sequence wrong");
endmodule // cpu_interrupt_entry_exit_checker
bind cpu_interrupt_entry_exit cpu_interrupt_entry_exit_checker #(.N(N),
  .FLAG_MASK(FLAG_MASK)) u_checker (.clock_i(clock_i), .rst_i(rst_i),
  .cond_i(cond_i), .enable_i(enable_i), .instr_done_i(instr_done_i),
  .cli_i(cli_i), .return_from_handler_i(return_from_handler_i),
  .status_we_i(status_we_i),
  .sleeping_i(sleeping_i), .stall_o(stall_o), .pc_load_o(pc_load_o),
  .pc_value_o(pc_value_o), .status_o(status_o), .flag_o(flag_o),
  .ack_o(ack_o), .sp_o(sp_o), .wake_o(wake_o));

// [dv/cpu_interrupt_entry_exit_tb.sv]
`timescale 1ns/1ps
`include "irq_defines.svh"
module cpu_interrupt_entry_exit_tb;
  import irq_pkg::*;
  logic clock_i, rst_i = 1'b1, sei = 1'b0, cli = 1'b0, ret_instr = 1'b0;
  logic st_we = 1'b0, asleep = 1'b0, slow = 1'b0, stall, pc_load, wake, done_w;
  logic [7:0] cond = 8'h00, en = 8'h00, fclr = 8'h00, flag, ack;
  byte_t st_wd = 8'h00, status;
  addr_t pc_w, pc_val, sp, pc_d1, stk[$];
  int miscompares = 0, compares = 0, ack_cnt = 0, nb, n0;
  core_model u_core_model (.clock_i(clock_i), .rst_i(rst_i), .stall_i(stall),
    .pc_load_i(pc_load), .pc_value_i(pc_val), .slow_i(slow),
    .asleep_i(asleep), .done_o(done_w), .pc_o(pc_w));
  // source 7 is level-type, the rest flag-type
  cpu_interrupt_entry_exit #(.N(8), .FLAG_MASK(8'h7f))
    u_cpu_interrupt_entry_exit (
    .clock_i(clock_i), .rst_i(rst_i), .cond_i(cond), .enable_i(en),
    .flag_clear_i(fclr), .instr_done_i(done_w), .sei_i(sei), .cli_i(cli),
    .return_from_handler_i(ret_instr), .status_we_i(st_we),
    .status_wdata_i(st_wd),
    .sp_we_i(1'b0), .sp_wdata_i(16'h0000), .sleeping_i(asleep),
    .pc_i(pc_w), .stall_o(stall), .pc_load_o(pc_load), .pc_value_o(pc_val),
    .status_o(status), .flag_o(flag), .ack_o(ack), .sp_o(sp), .wake_o(wake));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // return addresses as the core held them in the take cycle
  always @(posedge clock_i) begin
    if (|ack) begin
      stk.push_back(pc_d1);
      ack_cnt++;
    end
    if (wake) asleep <= 1'b0;
    pc_d1 <= pc_w;
  end
  function automatic logic [7:0] low(logic [7:0] v);
    return v & (~v + 8'h01);
  endfunction
  function automatic addr_t vec(logic [7:0] a);
    addr_t v;
    v = 16'h0000;
    for (int i = 0; i < 8; i++) if (a[i]) v = `VECTOR_STRIDE * addr_t'(i + 1);
    return v;
  endfunction
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  // one-cycle strobe: 0 condition, 1 flag clear, 2 status write
  task automatic pulse(input int k, input logic [7:0] v);
    @(posedge clock_i);
    if (k == 0) cond <= v;
    else if (k == 1) fclr <= v;
    else begin
      st_we <= 1'b1;
      st_wd <= v;
    end
    @(posedge clock_i);
    cond <= 8'h00;
    fclr <= 8'h00;
    st_we <= 1'b0;
    #1;
  endtask
  // held until a boundary consumes it: 0 enable, 1 disable, 2 return
  task automatic boundary(input int k);
    int i;
    @(posedge clock_i);
    if (k == 0) sei <= 1'b1;
    else if (k == 1) cli <= 1'b1;
    else ret_instr <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock_i);
      if (done_w && !stall) break;
    end
    if (i == 50) begin
      miscompares++;
      end_sim();
    end
    sei <= 1'b0;
    cli <= 1'b0;
    ret_instr <= 1'b0;
  endtask
  task automatic wait_load(input addr_t exp);
    int i;
    for (i = 0; i < 50 && !pc_load; i++) @(posedge clock_i);
    if (i == 50) begin
      miscompares++;
      end_sim();
    end
    chk(pc_val, exp);
  endtask
  // waits for a take, counting boundaries passed before it
  task automatic serve(input logic [7:0] exp, input logic w, output int n);
    int i;
    n = 0;
    for (i = 0; i < 300; i++) begin
      @(posedge clock_i);
      if (|ack) break;
      if (done_w) n++;
    end
    if (i == 300) begin
      miscompares++;
      end_sim();
    end
    chk(ack, exp);
    chk(status[7], 1'b0);
    chk(flag & exp, 8'h00);
    chk(wake, w);
    wait_load(vec(exp));
  endtask
  task automatic do_ret();
    boundary(2);
    wait_load(stk.pop_back());
    chk(status[7], 1'b1);
  endtask
  initial begin
    logic [7:0] c, e;
    void'($urandom(32'h0a2f38bc));
    repeat (4) @(posedge clock_i);
    #1;
    chk(sp, `SP_RESET);
    chk(status, `STATUS_RESET);
    @(posedge clock_i);
    rst_i <= 1'b0;
    tick(1);
    chk(pc_load, 1'b1);
    chk(pc_val, `RESET_VECTOR);
    // flags latch while disabled, clear on one, stay on zero
    pulse(0, 8'h0c);
    chk(flag, 8'h0c);
    pulse(1, 8'h04);
    chk(flag, 8'h08);
    pulse(0, 8'h06);
    chk(flag, 8'h0e);
    en <= 8'hff;
    tick(20);
    chk(ack_cnt, 0);
    pulse(2, 8'h80);
    serve(8'h02, 1'b0, nb);
    chk(sp, 16'h00fd);
    // nesting once the handler reopens the global enable
    pulse(2, 8'h80);
    serve(8'h04, 1'b0, nb);
    do_ret();
    serve(8'h08, 1'b0, nb);
    chk(nb >= 2, 1'b1);
    do_ret();
    do_ret();
    chk(sp, `SP_RESET);
    // disable blocks a request raised alongside it; the ticks let the
    // return shadow lapse, so only the disable can hold the take off
    tick(3);
    n0 = ack_cnt;
    cond <= 8'h10;
    boundary(1);
    cond <= 8'h00;
    tick(20);
    chk(ack_cnt, n0);
    boundary(0);
    serve(8'h10, 1'b0, nb);
    chk(nb >= 2, 1'b1);
    do_ret();
    // level source gone before it was enabled is lost
    en <= 8'h7f;
    cond <= 8'h80;
    tick(5);
    cond <= 8'h00;
    en <= 8'hff;
    tick(20);
    chk(ack_cnt, n0 + 1);
    cond <= 8'h80;
    serve(8'h80, 1'b0, nb);
    cond <= 8'h00;
    do_ret();
    // wake from sleep; the ticks let the return shadow lapse before the core sleeps
    tick(3);
    asleep <= 1'b1;
    tick(3);
    pulse(0, 8'h01);
    serve(8'h01, 1'b1, nb);
    do_ret();
    // random sources and enables, lowest enabled pending wins
    for (int r = 0; r < 24; r++) begin
      c = (8'($urandom) | 8'h40) & 8'h7f;
      e = 8'($urandom) | 8'h40;
      en <= e;
      slow <= 1'($urandom);
      pulse(0, c);
      serve(low(c & e), 1'b0, nb);
      en <= 8'h00;
      pulse(1, 8'hff);
      do_ret();
    end
    end_sim();
  end
endmodule // cpu_interrupt_entry_exit_tb
